// ### tmb_pkg.sv
// Constants shared by the capture timer register block
package tmb_pkg;
    // Register offsets on the byte bus
    localparam logic [3:0] OFF_IRQ_EN = 4'h5;
    localparam logic [3:0] OFF_IRQ_FLAG = 4'h6;
    localparam logic [3:0] OFF_RUN = 4'h7;
    localparam logic [3:0] OFF_DBG = 4'h8;
    localparam logic [3:0] OFF_STAGE = 4'h9;
    localparam logic [3:0] OFF_CNT_LO = 4'hA;
    localparam logic [3:0] OFF_CNT_HI = 4'hB;
    localparam logic [3:0] OFF_MATCH_CAPTURE_VALUE_LO = 4'hC;
    localparam logic [3:0] OFF_MATCH_CAPTURE_VALUE_HI = 4'hD;
    // Bit positions inside the one-bit registers
    localparam int BIT_SAMPLE_EVENT_IRQ = 0;
    localparam int BIT_RUN = 0;
    localparam int BIT_RUN_WHILE_HALTED = 0;
    // Reset values, counter bottom and count step
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    // Timer mode encodings
    localparam logic [2:0] MODE_INT = 3'h0;
    localparam logic [2:0] MODE_TIMEOUT = 3'h1;
    localparam logic [2:0] MODE_SAMPLE_EVENT_IRQ = 3'h2;
    localparam logic [2:0] MODE_FRQ = 3'h3;
    localparam logic [2:0] MODE_PW = 3'h4;
    localparam logic [2:0] MODE_FRQPW = 3'h5;
    localparam logic [2:0] MODE_SINGLE = 3'h6;
    localparam logic [2:0] MODE_PWM8 = 3'h7;
    // Phases of the combined frequency and pulse-width measurement
    typedef enum logic [1:0] {
        FP_IDLE,
        FP_HIGH,
        FP_LOW
    } tmb_phase_e;
endpackage : tmb_pkg

// ### tmb_capture_timer.sv
// Capture timer: interrupt, status, debug, staging, counter and capture registers
`timescale 1ns/1ps
`default_nettype none

module tmb_capture_timer (
    input wire logic mclk,              // Peripheral clock
    input wire logic rst,               // Asynchronous reset, active high
    input wire logic clk_en,            // Freezes all state while low
    input wire logic [3:0] bus_addr,    // Byte offset
    input wire logic [7:0] bus_wdata,   // Write data
    input wire logic bus_wr,            // Write strobe
    input wire logic bus_rd,            // Read strobe
    input wire logic bus_from_debug,    // Access comes from the debug port
    output logic [7:0] bus_rdata,       // Read data, registered
    input wire logic timer_enable,      // Peripheral enable
    input wire logic [2:0] timer_mode_select, // Timer mode
    input wire logic event_input_enable, // Event input enable
    input wire logic event_edge,        // Event edge polarity select
    input wire logic event_in,          // Event level from event routing
    input wire logic cpu_halted,        // CPU stopped in break debug
    output logic sample_event_irq,      // Capture interrupt request
    output logic pwm_out                // PWM8 waveform
);

    // Register state
    logic [15:0] cnt_r, cnt_nxt;        // Counter
    logic [15:0] match_capture_value_r, match_capture_value_nxt;      // Capture/compare
    logic [7:0] stage_r;                // Shared staging byte
    logic irq_en_r;                     // Capture interrupt enable
    logic flag_r;                       // Capture flag
    logic run_while_halted_r;                     // Keep running in debug halt
    logic run_r, run_nxt;               // Counter running
    logic ev_prev_r;                    // Previous event level
    logic [7:0] rdata_r;                // Registered read data
    logic pwm_r, pwm_nxt;               // PWM waveform
    tmb_pkg::tmb_phase_e phase_r, phase_nxt; // Combined-mode phase
    logic flag_set;                     // Hardware sets the flag

    // Bus decode
    wire wr_en = clk_en & bus_wr;
    wire rd_en = clk_en & bus_rd;
    wire wr_cnt_lo = wr_en & (bus_addr == tmb_pkg::OFF_CNT_LO);
    wire wr_match_capture_value_lo = wr_en & (bus_addr == tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO);
    wire wr_hi = wr_en & ((bus_addr == tmb_pkg::OFF_CNT_HI) |
                          (bus_addr == tmb_pkg::OFF_MATCH_CAPTURE_VALUE_HI));
    wire wr_stage = wr_en & (bus_addr == tmb_pkg::OFF_STAGE);
    wire rd_cnt_lo = rd_en & (bus_addr == tmb_pkg::OFF_CNT_LO);
    wire rd_match_capture_value_lo = rd_en & (bus_addr == tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO);
    wire wr_flag_clr = wr_en & (bus_addr == tmb_pkg::OFF_IRQ_FLAG) &
                       bus_wdata[tmb_pkg::BIT_SAMPLE_EVENT_IRQ];

    // Mode decode
    wire [2:0] mode = timer_mode_select;
    wire capture_mode = (mode == tmb_pkg::MODE_SAMPLE_EVENT_IRQ) | (mode == tmb_pkg::MODE_FRQ) |
                        (mode == tmb_pkg::MODE_PW) | (mode == tmb_pkg::MODE_FRQPW);

    // Timer advances only when enabled and not held by a debug break
    wire tick = clk_en & timer_enable & ~(cpu_halted & ~run_while_halted_r);

    // Event edges, honoured only while ticking and with the input enabled
    wire ev_ok = tick & event_input_enable;
    wire ev_pos = ev_ok & event_in & ~ev_prev_r;
    wire ev_neg = ev_ok & ~event_in & ev_prev_r;
    wire ev_act = event_edge ? ev_neg : ev_pos;   // Primary edge
    wire ev_opp = event_edge ? ev_pos : ev_neg;   // Opposite edge

    // Top comparisons
    wire at_top16 = (cnt_r == match_capture_value_r);
    wire at_top8 = (cnt_r[7:0] == match_capture_value_r[7:0]);
    wire [15:0] cnt_inc = cnt_r + tmb_pkg::CNT_STEP;

    // Mode sequencing: counter, capture, run state and flag set
    always_comb begin
        cnt_nxt = cnt_r;
        match_capture_value_nxt = match_capture_value_r;
        run_nxt = run_r;
        phase_nxt = phase_r;
        pwm_nxt = pwm_r;
        flag_set = 1'b0;
        if (!timer_enable) begin
            // Disabled timer is stopped
            run_nxt = 1'b0;
            phase_nxt = tmb_pkg::FP_IDLE;
        end else if (tick) begin
            unique case (mode)
                tmb_pkg::MODE_INT: begin
                    run_nxt = 1'b1;
                    if (at_top16) begin
                        cnt_nxt = tmb_pkg::CNT_BOTTOM;
                        flag_set = 1'b1;
                    end else begin
                        cnt_nxt = cnt_inc;
                    end
                end
                tmb_pkg::MODE_TIMEOUT: begin
                    // Primary edge starts, opposite edge stops
                    if (ev_act) begin
                        run_nxt = 1'b1;
                    end else if (ev_opp) begin
                        run_nxt = 1'b0;
                    end
                    if (run_r) begin
                        if (at_top16) begin
                            cnt_nxt = tmb_pkg::CNT_BOTTOM;
                            flag_set = 1'b1;
                        end else begin
                            cnt_nxt = cnt_inc;
                        end
                    end
                end
                tmb_pkg::MODE_SAMPLE_EVENT_IRQ: begin
                    run_nxt = 1'b1;
                    cnt_nxt = cnt_inc;
                    if (ev_act) begin
                        match_capture_value_nxt = cnt_r;
                        flag_set = 1'b1;
                    end
                end
                tmb_pkg::MODE_FRQ: begin
                    run_nxt = 1'b1;
                    if (ev_act) begin
                        match_capture_value_nxt = cnt_r;
                        cnt_nxt = tmb_pkg::CNT_BOTTOM;
                        flag_set = 1'b1;
                    end else begin
                        cnt_nxt = cnt_inc;
                    end
                end
                tmb_pkg::MODE_PW: begin
                    run_nxt = 1'b1;
                    if (ev_act) begin
                        cnt_nxt = tmb_pkg::CNT_BOTTOM;
                    end else begin
                        cnt_nxt = cnt_inc;
                        if (ev_opp) begin
                            match_capture_value_nxt = cnt_r;
                            flag_set = 1'b1;
                        end
                    end
                end
                tmb_pkg::MODE_FRQPW: begin
                    if (run_r) begin
                        cnt_nxt = cnt_inc;
                    end
                    unique case (phase_r)
                        tmb_pkg::FP_IDLE: begin
                            // First primary edge clears and starts
                            if (ev_act) begin
                                cnt_nxt = tmb_pkg::CNT_BOTTOM;
                                run_nxt = 1'b1;
                                phase_nxt = tmb_pkg::FP_HIGH;
                            end
                        end
                        tmb_pkg::FP_HIGH: begin
                            // Opposite edge captures the pulse width
                            if (ev_opp) begin
                                match_capture_value_nxt = cnt_r;
                                phase_nxt = tmb_pkg::FP_LOW;
                            end
                        end
                        tmb_pkg::FP_LOW: begin
                            // Second primary edge stops and flags
                            if (ev_act) begin
                                run_nxt = 1'b0;
                                cnt_nxt = cnt_r;
                                flag_set = 1'b1;
                                phase_nxt = tmb_pkg::FP_IDLE;
                            end
                        end
                        default: begin
                            phase_nxt = tmb_pkg::FP_IDLE;
                        end
                    endcase
                end
                tmb_pkg::MODE_SINGLE: begin
                    // Either edge starts when edge select is set
                    if (!run_r && (ev_act || (event_edge && ev_opp))) begin
                        run_nxt = 1'b1;
                    end
                    if (run_r) begin
                        if (at_top16) begin
                            cnt_nxt = tmb_pkg::CNT_BOTTOM;
                            run_nxt = 1'b0;
                            flag_set = 1'b1;
                        end else begin
                            cnt_nxt = cnt_inc;
                        end
                    end
                end
                tmb_pkg::MODE_PWM8: begin
                    run_nxt = 1'b1;
                    if (at_top8) begin
                        cnt_nxt = tmb_pkg::CNT_BOTTOM;
                        flag_set = 1'b1;
                        pwm_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_inc;
                        if (cnt_r[7:0] == match_capture_value_r[15:8]) begin
                            pwm_nxt = 1'b0;
                        end
                    end
                end
            endcase
        end
        // Writes of the low byte commit the staged high byte
        if (wr_cnt_lo) begin
            cnt_nxt = {stage_r, bus_wdata};
        end
        if (wr_match_capture_value_lo) begin
            match_capture_value_nxt = {stage_r, bus_wdata};
        end
    end

    // Read data selection; low-byte reads return the live low byte
    wire [7:0] rd_sel =
        (bus_addr == tmb_pkg::OFF_IRQ_EN) ? {7'h00, irq_en_r} :
        (bus_addr == tmb_pkg::OFF_IRQ_FLAG) ? {7'h00, flag_r} :
        (bus_addr == tmb_pkg::OFF_RUN) ? {7'h00, run_r} :
        (bus_addr == tmb_pkg::OFF_DBG) ? {7'h00, run_while_halted_r} :
        (bus_addr == tmb_pkg::OFF_STAGE) ? stage_r :
        (bus_addr == tmb_pkg::OFF_CNT_LO) ? cnt_r[7:0] :
        (bus_addr == tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO) ? match_capture_value_r[7:0] :
        ((bus_addr == tmb_pkg::OFF_CNT_HI) ||
         (bus_addr == tmb_pkg::OFF_MATCH_CAPTURE_VALUE_HI)) ? stage_r :
        tmb_pkg::RST_BYTE;

    // Flag clear sources; a hardware set in the same cycle wins
    wire flag_clr = wr_flag_clr | (rd_match_capture_value_lo & capture_mode);

    // Counter, capture and run state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= tmb_pkg::RST_WORD;
            match_capture_value_r <= tmb_pkg::RST_WORD;
            run_r <= 1'b0;
            phase_r <= tmb_pkg::FP_IDLE;
            pwm_r <= 1'b0;
            ev_prev_r <= 1'b0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
            match_capture_value_r <= match_capture_value_nxt;
            run_r <= run_nxt;
            phase_r <= phase_nxt;
            pwm_r <= pwm_nxt;
            if (tick) begin
                ev_prev_r <= event_in;
            end
        end
    end

    // Flag with set priority over clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (clk_en) begin
            flag_r <= flag_set | (flag_r & ~flag_clr);
        end
    end

    // Control registers; run bit ignores all writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_en_r <= 1'b0;
            run_while_halted_r <= 1'b0;
        end else if (wr_en) begin
            if (bus_addr == tmb_pkg::OFF_IRQ_EN) begin
                irq_en_r <= bus_wdata[tmb_pkg::BIT_SAMPLE_EVENT_IRQ];
            end
            if (bus_addr == tmb_pkg::OFF_DBG) begin
                run_while_halted_r <= bus_wdata[tmb_pkg::BIT_RUN_WHILE_HALTED];
            end
        end
    end

    // Staging byte: high writes, direct writes, low-byte reads
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage_r <= tmb_pkg::RST_BYTE;
        end else if (wr_hi || wr_stage) begin
            stage_r <= bus_wdata;
        end else if (rd_cnt_lo) begin
            stage_r <= cnt_r[15:8];
        end else if (rd_match_capture_value_lo) begin
            stage_r <= match_capture_value_r[15:8];
        end
    end

    // Registered read data
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= tmb_pkg::RST_BYTE;
        end else if (rd_en) begin
            rdata_r <= rd_sel;
        end
    end

    assign bus_rdata = rdata_r;
    assign sample_event_irq = flag_r & irq_en_r;
    assign pwm_out = pwm_r;

endmodule : tmb_capture_timer

`default_nettype wire

// ### tmb_capture_timer_assertions.sv
// Port-level checker for the capture timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module tmb_capture_timer_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_from_debug,
    input wire logic [7:0] bus_rdata,
    input wire logic timer_enable,
    input wire logic [2:0] timer_mode_select,
    input wire logic event_input_enable,
    input wire logic event_edge,
    input wire logic event_in,
    input wire logic cpu_halted,
    input wire logic sample_event_irq,
    input wire logic pwm_out
);
    logic en_r; // Copy of the capture interrupt enable bit
    logic dbg_r; // Copy of the debug-run bit
    // Events off in a mode whose flag only events can set
    wire logic no_src = !event_input_enable &&
        timer_mode_select inside {[tmb_pkg::MODE_SAMPLE_EVENT_IRQ:tmb_pkg::MODE_FRQPW]};
    wire logic tick = clk_en && timer_enable && !cpu_halted; // Timer advances
    wire logic en_wr = clk_en && bus_wr && bus_addr == tmb_pkg::OFF_IRQ_EN; // Enable write
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Follow the two control bits written over the bus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_r <= 1'h0;
            dbg_r <= 1'h0;
        end else if (en_wr) begin
            en_r <= bus_wdata[0];
        end else if (clk_en && bus_wr && bus_addr == tmb_pkg::OFF_DBG) begin
            dbg_r <= bus_wdata[0];
        end
    end
    sequence s_wr(a);
        clk_en && bus_wr && bus_addr == a;
    endsequence
    sequence s_rd(a);
        clk_en && bus_rd && bus_addr == a;
    endsequence
    irq_gate_a: assert property (en_wr ##0 !bus_wdata[0] |=> !sample_event_irq)
        else $error("irq high with enable cleared");
    flag_w1c_a: assert property (s_wr(tmb_pkg::OFF_IRQ_FLAG) ##0 (bus_wdata[0] && no_src)
        |=> !sample_event_irq) else $error("flag survived write of one");
    sample_event_irq_rd_a: assert property (s_rd(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO) ##0 no_src |=> !sample_event_irq)
        else $error("flag survived capture read");
    sample_event_irq_evt_a: assert property (tick && $past(tick) && en_r && !en_wr && !event_edge &&
        event_input_enable && timer_mode_select == tmb_pkg::MODE_SAMPLE_EVENT_IRQ && $rose(event_in)
        |=> sample_event_irq) else $error("capture event raised no irq");
    halt_evt_a: assert property (!dbg_r && cpu_halted && clk_en && !en_wr &&
        !sample_event_irq |=> !sample_event_irq) else $error("flag set while halted");
    run_idle_a: assert property (s_rd(tmb_pkg::OFF_RUN) ##0
        (!timer_enable && !$past(timer_enable)) |=> bus_rdata == 8'h00)
        else $error("run bit set while stopped");
    cnt_pair_a: assert property (s_wr(tmb_pkg::OFF_CNT_HI) ##1 s_wr(tmb_pkg::OFF_CNT_LO)
        ##1 s_rd(tmb_pkg::OFF_CNT_LO) |=> bus_rdata == $past(bus_wdata, 2))
        else $error("counter low byte lost");
    stage_hi_a: assert property (s_wr(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_HI) ##1 s_wr(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO)
        ##1 s_rd(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO) ##1 s_rd(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_HI) ##0 !event_input_enable
        |=> bus_rdata == $past(bus_wdata, 4)) else $error("staged high byte lost");
endmodule : tmb_capture_timer_chk
bind tmb_capture_timer tmb_capture_timer_chk u_chk (.mclk, .rst, .clk_en, .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_from_debug, .bus_rdata, .timer_enable,
    .timer_mode_select, .event_input_enable, .event_edge, .event_in, .cpu_halted,
    .sample_event_irq, .pwm_out);
`default_nettype wire

// ### tb_tmb_capture_timer.sv
// Self-checking bench for the capture timer register block
`timescale 1ns/1ps
`default_nettype none
module tb_tmb_capture_timer;
    logic mclk, rst, clk_en, bus_wr, bus_rd, bus_from_debug, timer_enable; // Bus and control
    logic event_input_enable, event_edge, event_in, cpu_halted, sample_event_irq, pwm_out;
    logic [3:0] bus_addr; // Byte offset
    logic [7:0] bus_wdata, bus_rdata, rv; // Bus data and one read-back byte
    logic [2:0] timer_mode_select; // Mode in use
    logic [15:0] w1, w2; // Word read-backs
    int err_total = 0, checks = 0, cyc = 0, n = 0; // Tallies
    tmb_capture_timer dut (.mclk, .rst, .clk_en, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_from_debug, .bus_rdata, .timer_enable, .timer_mode_select, .event_input_enable,
        .event_edge, .event_in, .cpu_halted, .sample_event_irq, .pwm_out);
    // Free-running 50 MHz clock
    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end
    // Cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Bus strobes stay up until the next access or idle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_rd = 1'h0;
        bus_wr = 1'h1;
        bus_addr = a;
        bus_wdata = d;
        @(negedge mclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus_wr = 1'h0;
        bus_rd = 1'h1;
        bus_addr = a;
        @(negedge mclk);
        d = bus_rdata;
    endtask : rd
    task automatic idle;
        bus_wr = 1'h0;
        bus_rd = 1'h0;
        @(negedge mclk);
    endtask : idle
    // Word access: high then low on writes, low then high on reads
    task automatic wr16(input logic [3:0] a, input logic [15:0] w);
        wr(a + 4'h1, w[15:8]);
        wr(a, w[7:0]);
    endtask : wr16
    task automatic rd16(input logic [3:0] a, output logic [15:0] w);
        rd(a, w[7:0]);
        rd(a + 4'h1, w[15:8]);
    endtask : rd16
    task automatic waitirq;
        n = 0;
        while (sample_event_irq !== 1'h1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
    endtask : waitirq
    task automatic t_reg;
        for (int a = 5; a < 15; a++) begin
            rd(4'(a), rv);
            chk("reset value", 16'(rv), 16'h0000);
        end
        wr(tmb_pkg::OFF_IRQ_EN, 8'h00);
        wr(tmb_pkg::OFF_IRQ_EN, 8'h01);
        wr(tmb_pkg::OFF_STAGE, 8'hA5);
        bus_from_debug = 1'h1;
        wr(tmb_pkg::OFF_RUN, 8'hFF);
        bus_from_debug = 1'h0;
        rd(tmb_pkg::OFF_RUN, rv);
        chk("run bit", 16'(rv), 16'h0000);
        rd(tmb_pkg::OFF_STAGE, rv);
        chk("staging", 16'(rv), 16'h00A5);
        rd(tmb_pkg::OFF_IRQ_EN, rv);
        chk("irq enable", 16'(rv), 16'h0001);
    endtask : t_reg
    task automatic t_pair;
        wr16(tmb_pkg::OFF_CNT_LO, 16'h1234);
        rd16(tmb_pkg::OFF_CNT_LO, w1);
        chk("counter", w1, 16'h1234);
        wr(tmb_pkg::OFF_CNT_HI, 8'h77);
        rd16(tmb_pkg::OFF_CNT_LO, w1);
        chk("lone high", w1, 16'h1234);
        wr16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, 16'hBEEF);
        rd16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, w1);
        chk("compare", w1, 16'hBEEF);
        rd(tmb_pkg::OFF_STAGE, rv);
        chk("staged", 16'(rv), 16'h00BE);
    endtask : t_pair
    // Cycles between a flag clear and the next top match
    task automatic t_per(input logic [2:0] m, input logic [15:0] top, input logic [15:0] e);
        timer_enable = 1'h0;
        timer_mode_select = m;
        wr16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, top);
        wr16(tmb_pkg::OFF_CNT_LO, 16'h0000);
        wr(tmb_pkg::OFF_IRQ_FLAG, 8'h01);
        idle();
        timer_enable = 1'h1;
        waitirq();
        wr(tmb_pkg::OFF_IRQ_FLAG, 8'h01);
        idle();
        waitirq();
        chk("period", 16'(n), e);
        // PWM8: output high from wrap until the low byte meets the high compare byte
        if (m == tmb_pkg::MODE_PWM8) begin
            n = 0;
            repeat (10) begin
                @(negedge mclk);
                n += int'(pwm_out);
            end
            chk("duty", 16'(n), 16'h0004);
        end
        rd(tmb_pkg::OFF_RUN, rv);
        chk("running", 16'(rv), 16'h0001);
    endtask : t_per
    task automatic t_halt;
        wr16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, 16'h1000);
        wr16(tmb_pkg::OFF_CNT_LO, 16'h0100);
        rd16(tmb_pkg::OFF_CNT_LO, w1);
        chk("write wins", w1, 16'h0100);
        cpu_halted = 1'h1;
        rd16(tmb_pkg::OFF_CNT_LO, w1);
        rd16(tmb_pkg::OFF_CNT_LO, w2);
        chk("halted", w2, w1);
        wr(tmb_pkg::OFF_DBG, 8'h01);
        rd16(tmb_pkg::OFF_CNT_LO, w1);
        rd16(tmb_pkg::OFF_CNT_LO, w2);
        chk("debug run", w2 - w1, 16'h0002);
        cpu_halted = 1'h0;
        wr(tmb_pkg::OFF_DBG, 8'h00);
    endtask : t_halt
    task automatic t_sample_event_irq;
        timer_mode_select = tmb_pkg::MODE_SAMPLE_EVENT_IRQ;
        wr(tmb_pkg::OFF_IRQ_FLAG, 8'h01);
        event_in = 1'h1;
        idle();
        chk("event off", 16'(sample_event_irq), 16'h0000);
        event_in = 1'h0;
        event_input_enable = 1'h1;
        idle();
        event_in = 1'h1;
        idle();
        chk("capture irq", 16'(sample_event_irq), 16'h0001);
        event_in = 1'h0;
        rd16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, w1);
        idle();
        chk("read clears", 16'(sample_event_irq), 16'h0000);
        event_in = 1'h1;
        idle();
        rd16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, w2);
        chk("capture gap", w2 - w1, 16'h0004);
        event_in = 1'h0;
    endtask : t_sample_event_irq
    // Frequency: rise to rise; pulse width: rise to fall; six cycles apart
    task automatic t_meas(input logic [2:0] m);
        timer_mode_select = m;
        idle();
        // Drop any flag left by the mode change; in frequency mode the first rise sets it again
        wr(tmb_pkg::OFF_IRQ_FLAG, 8'h01);
        idle();
        event_in = 1'h1;
        repeat (3) @(negedge mclk);
        event_in = (m == tmb_pkg::MODE_FRQ) ? 1'h0 : 1'h1;
        repeat (3) @(negedge mclk);
        event_in = ~event_in;
        idle();
        chk("measure irq", 16'(sample_event_irq), 16'h0001);
        rd16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, w1);
        chk("measured", w1, 16'h0005);
        event_in = 1'h0;
    endtask : t_meas
    // Combined mode: rise starts, fall captures, second rise stops and flags
    task automatic t_fpw;
        timer_mode_select = tmb_pkg::MODE_FRQPW;
        wr(tmb_pkg::OFF_IRQ_FLAG, 8'h01);
        idle();
        event_in = 1'h1;
        repeat (3) @(negedge mclk);
        event_in = 1'h0;
        repeat (3) @(negedge mclk);
        chk("no early flag", 16'(sample_event_irq), 16'h0000);
        event_in = 1'h1;
        idle();
        chk("second edge irq", 16'(sample_event_irq), 16'h0001);
        rd(tmb_pkg::OFF_RUN, rv);
        chk("stopped", 16'(rv), 16'h0000);
        rd16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, w1);
        chk("pulse width", w1, 16'h0002);
        rd16(tmb_pkg::OFF_CNT_LO, w2);
        chk("held count", w2, 16'h0005);
        event_in = 1'h0;
    endtask : t_fpw
    // Single-shot waits for an edge and stops at top; time-out wraps and runs on
    task automatic t_shot;
        timer_enable = 1'h0;
        timer_mode_select = tmb_pkg::MODE_SINGLE;
        wr16(tmb_pkg::OFF_MATCH_CAPTURE_VALUE_LO, 16'h0004);
        wr16(tmb_pkg::OFF_CNT_LO, 16'h0000);
        wr(tmb_pkg::OFF_IRQ_FLAG, 8'h01);
        idle();
        timer_enable = 1'h1;
        repeat (8) @(negedge mclk);
        chk("armed", 16'(sample_event_irq), 16'h0000);
        event_in = 1'h1;
        waitirq();
        chk("single shot", 16'(n), 16'h0006);
        rd(tmb_pkg::OFF_RUN, rv);
        chk("shot done", 16'(rv), 16'h0000);
        timer_mode_select = tmb_pkg::MODE_TIMEOUT;
        event_in = 1'h0;
        wr(tmb_pkg::OFF_IRQ_FLAG, 8'h01);
        idle();
        event_in = 1'h1;
        waitirq();
        chk("time-out", 16'(n), 16'h0006);
        rd(tmb_pkg::OFF_RUN, rv);
        chk("still running", 16'(rv), 16'h0001);
        event_in = 1'h0;
    endtask : t_shot
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        {rst, clk_en, bus_wr, bus_rd, bus_from_debug, timer_enable} = 6'h30;
        {event_input_enable, event_edge, event_in, cpu_halted} = 4'h0;
        {bus_addr, bus_wdata} = 12'h000;
        timer_mode_select = tmb_pkg::MODE_SAMPLE_EVENT_IRQ;
        repeat (3) @(negedge mclk);
        rst = 1'h0;
        t_reg();
        t_pair();
        $display("register tests done");
        t_per(tmb_pkg::MODE_PWM8, 16'h0309, 16'h0008);
        t_per(tmb_pkg::MODE_INT, 16'h0040, 16'h003F);
        t_halt();
        $display("count tests done");
        t_sample_event_irq();
        t_meas(tmb_pkg::MODE_FRQ);
        t_meas(tmb_pkg::MODE_PW);
        t_fpw();
        t_shot();
        $display("capture tests done");
        close_out();
    end
endmodule : tb_tmb_capture_timer
`default_nettype wire
